// ### fep_pkg.sv
package fep_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  localparam logic [7:0] WDATA_OFS = 8'h0c;
  localparam logic [7:0] RDATA_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] FUSE_OFS = 8'h18;
  // command codes in cmd[1:0]
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  // address register fields
  localparam int ADDR_W = 10;
  localparam int SPACE_LSB = 10;
  localparam logic [1:0] SPACE_CODE = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_USER = 2'h2;
  // fuse register bit positions
  localparam int F_SERIAL = 0;
  localparam int F_UR_ERASE = 1;
  localparam int F_UR_ACCESS = 2;
  localparam int F_CLK_SRC = 3;
  localparam int F_LOCK1 = 4;
  localparam int F_LOCK2 = 5;
  localparam int FUSE_W = 6;
  localparam logic [5:0] FUSE_RST = 6'h05;
  // status register bit positions
  localparam int S_BUSY = 0;
  localparam int S_ERASING = 1;
  localparam int S_SERIAL = 2;
  localparam int S_FUSE_LSB = 8;
  // signature locations and values
  localparam logic [9:0] SIG_ADDR0 = 10'h030;
  localparam logic [9:0] SIG_ADDR1 = 10'h031;
  localparam logic [7:0] SIG_VAL0 = 8'h5a; // arbitrary value
  localparam logic [7:0] SIG_VAL1 = 8'h3c; // arbitrary value
  localparam logic [7:0] BLOCKED_RD = 8'hff;
  localparam logic [7:0] ERASED = 8'hff;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int ERASE_MS = 8;
  localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  localparam int WRITE_CYC = 16;
  localparam int CNT_W = 20;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_ERASE = 4'b1000
  } fep_state_t;
endpackage

// ### fep_prog.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - during a write, polling the last byte returns inverted bit 7
// - after the write finishes, true stored data is returned
// - parallel mode: ready/busy driven low after strobe rises, released when done
// - array read-back only while neither lock bit is programmed
// - lock bit state readable directly in both modes
// - chip erase sets every code and data array bit to one
// - chip erase clears user row only when its erase fuse is zero
// - serial chip erase started by instruction, self-timed about 8 ms
// - serial reads return 00 during chip erase
// - serial fuse disable from either mode, enable only in parallel mode
// - serial programming fuse resets to enabled
// - locations 030 and 031 with both selects low return identity codes
// - user row access fuse allows or blocks user row writes
// - clock source fuse picks external clock or crystal
module fep_prog #(
  parameter int CODE_DEPTH = 64,
  parameter int DATA_DEPTH = 32,
  parameter int USER_DEPTH = 8,
  parameter int WRITE_CYCLES = fep_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = fep_pkg::ERASE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic address_latch_strobe,
  input wire logic signature_select_a,
  input wire logic signature_select_b,
  output logic ready_busy_pin_o,
  output logic ready_busy_pin_oe,
  output logic clock_source_fuse,
  output logic serial_prog_enabled
);
  import fep_pkg::*;

  fep_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic serial_q, serial_d;
  logic [11:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [11:0] last_q, last_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic [FUSE_W-1:0] fuse_q, fuse_d;
  logic [31:0] prdata_q, prdata_d;
  logic ale_q;
  logic [7:0] code_mem [CODE_DEPTH];
  logic [7:0] data_mem [DATA_DEPTH];
  logic [7:0] user_mem [USER_DEPTH];
  logic rd_setup, apb_wr, mapped, cmd_ok, ale_rise, prog_done, erase_done, locked;
  logic [7:0] rd_byte;

  // decode shared by the write strobe and the error answer
  function automatic logic is_mapped(input logic [7:0] a);
    return a == CTRL_OFS || a == CMD_OFS || a == ADDR_OFS || a == WDATA_OFS ||
           a == RDATA_OFS || a == STATUS_OFS || a == FUSE_OFS;
  endfunction

  // fetch one byte from the selected array
  function automatic logic [7:0] mem_byte(input logic [11:0] a);
    logic [7:0] v;
    v = ERASED;
    unique case (a[SPACE_LSB +: 2])
      SPACE_CODE: v = code_mem[a[$clog2(CODE_DEPTH)-1:0]];
      SPACE_DATA: v = data_mem[a[$clog2(DATA_DEPTH)-1:0]];
      SPACE_USER: v = user_mem[a[$clog2(USER_DEPTH)-1:0]];
      default: v = ERASED;
    endcase
    return v;
  endfunction

  // zero-wait slave: data is captured in setup, answered in the first access cycle
  assign rd_setup = psel && !penable && !pwrite;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign mapped = is_mapped(paddr);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;
  // serial commands are dead once the serial fuse is blown
  assign cmd_ok = !serial_q || fuse_q[F_SERIAL];
  assign ale_rise = address_latch_strobe && !ale_q;
  assign prog_done = st_q == ST_WRITE && cnt_q == '0;
  assign erase_done = st_q == ST_ERASE && cnt_q == '0;
  assign locked = fuse_q[F_LOCK1] || fuse_q[F_LOCK2];
  // open-drain busy: pull low only while a parallel byte write runs
  assign ready_busy_pin_o = 1'b0;
  assign ready_busy_pin_oe = st_q == ST_WRITE && !serial_q;
  assign clock_source_fuse = fuse_q[F_CLK_SRC];
  assign serial_prog_enabled = fuse_q[F_SERIAL];

  // read mux, highest priority first
  always_comb begin
    rd_byte = mem_byte(addr_q);
    if (serial_q && st_q == ST_ERASE) begin
      rd_byte = 8'h00;
    end else if (st_q == ST_WRITE && addr_q == last_q) begin
      rd_byte = {~wbyte_q[7], wbyte_q[6:0]};
    end else if (!signature_select_a && !signature_select_b && addr_q[ADDR_W-1:0] == SIG_ADDR0) begin
      rd_byte = SIG_VAL0;
    end else if (!signature_select_a && !signature_select_b && addr_q[ADDR_W-1:0] == SIG_ADDR1) begin
      rd_byte = SIG_VAL1;
    end else if (locked) begin
      rd_byte = BLOCKED_RD;
    end
  end

  // register file and sequencer next values
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    serial_d = serial_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    last_d = last_q;
    wbyte_d = wbyte_q;
    fuse_d = fuse_q;
    prdata_d = prdata_q;
    if (rd_setup) begin
      prdata_d = 32'h0;
      unique case (paddr)
        CTRL_OFS: prdata_d = {31'h0, serial_q};
        ADDR_OFS: prdata_d = {20'h0, addr_q};
        WDATA_OFS: prdata_d = {24'h0, wdata_q};
        RDATA_OFS: prdata_d = {24'h0, rd_byte};
        STATUS_OFS: prdata_d = {18'h0, fuse_q, 5'h0, serial_q, st_q == ST_ERASE, st_q != ST_IDLE};
        FUSE_OFS: prdata_d = {26'h0, fuse_q};
        default: prdata_d = 32'h0;
      endcase
    end
    if (apb_wr && st_q == ST_IDLE) begin
      if (paddr == CTRL_OFS) begin
        serial_d = pwdata[0];
      end
      if (paddr == ADDR_OFS) begin
        addr_d = pwdata[11:0];
      end
      if (paddr == WDATA_OFS) begin
        wdata_d = pwdata[7:0];
      end
      if (paddr == FUSE_OFS && cmd_ok) begin
        fuse_d = pwdata[FUSE_W-1:0];
        // lock bits only program; erase is the way back
        fuse_d[F_LOCK1] = fuse_q[F_LOCK1] || pwdata[F_LOCK1];
        fuse_d[F_LOCK2] = fuse_q[F_LOCK2] || pwdata[F_LOCK2];
        fuse_d[F_SERIAL] = serial_q ? fuse_q[F_SERIAL] && pwdata[F_SERIAL] : pwdata[F_SERIAL];
      end
    end
    unique case (st_q)
      ST_IDLE: begin
        if (apb_wr && paddr == CMD_OFS && cmd_ok) begin
          if (pwdata[1:0] == OP_PROG && (addr_q[SPACE_LSB +: 2] != SPACE_USER || fuse_q[F_UR_ACCESS])) begin
            last_d = addr_q;
            wbyte_d = wdata_q;
            cnt_d = CNT_W'(WRITE_CYCLES - 1);
            // parallel writes wait for the address latch strobe
            st_d = serial_q ? ST_WRITE : ST_ARM;
          end else if (pwdata[1:0] == OP_ERASE) begin
            cnt_d = CNT_W'(ERASE_CYCLES - 1);
            st_d = ST_ERASE;
          end
        end
      end
      ST_ARM: begin
        if (ale_rise) begin
          st_d = ST_WRITE;
        end
      end
      ST_WRITE, ST_ERASE: begin
        if (cnt_q == '0) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
        if (erase_done) begin
          fuse_d[F_LOCK1] = 1'b0;
          fuse_d[F_LOCK2] = 1'b0;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      serial_q <= 1'b0;
      addr_q <= 12'h000;
      wdata_q <= 8'h00;
      last_q <= 12'h000;
      wbyte_q <= 8'h00;
      fuse_q <= FUSE_RST;
      prdata_q <= 32'h0;
      ale_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      serial_q <= serial_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      last_q <= last_d;
      wbyte_q <= wbyte_d;
      fuse_q <= fuse_d;
      prdata_q <= prdata_d;
      ale_q <= address_latch_strobe;
    end
  end

  // arrays commit at the end of the self-timed cycle, no reset
  always_ff @(posedge pclk) begin
    if (erase_done) begin
      for (int i = 0; i < CODE_DEPTH; i++) begin
        code_mem[i] <= ERASED;
      end
      for (int i = 0; i < DATA_DEPTH; i++) begin
        data_mem[i] <= ERASED;
      end
      if (!fuse_q[F_UR_ERASE]) begin
        for (int i = 0; i < USER_DEPTH; i++) begin
          user_mem[i] <= ERASED;
        end
      end
    end else if (prog_done) begin
      unique case (last_q[SPACE_LSB +: 2])
        SPACE_CODE: code_mem[last_q[$clog2(CODE_DEPTH)-1:0]] <= wbyte_q;
        SPACE_DATA: data_mem[last_q[$clog2(DATA_DEPTH)-1:0]] <= wbyte_q;
        SPACE_USER: user_mem[last_q[$clog2(USER_DEPTH)-1:0]] <= wbyte_q;
        default: ;
      endcase
    end
  end

  property p_poll;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == RDATA_OFS && st_q == ST_WRITE && addr_q == last_q
    |=> prdata[7] == !$past(wbyte_q[7]);
  endproperty
  a_poll: assert property (p_poll) else $error("poll bit not inverted");

  property p_true;
    @(posedge pclk) disable iff (!presetn)
    prog_done && last_q[SPACE_LSB +: 2] == SPACE_CODE
    |=> code_mem[$past(last_q[$clog2(CODE_DEPTH)-1:0])] == $past(wbyte_q);
  endproperty
  a_true: assert property (p_true) else $error("written byte not stored");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_ARM && ale_rise && !serial_q |=> ready_busy_pin_oe [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not driven after strobe");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    prog_done |=> !ready_busy_pin_oe && st_q == ST_IDLE;
  endproperty
  a_ready: assert property (p_ready) else $error("busy not released");

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == RDATA_OFS && st_q == ST_IDLE && locked && signature_select_a
    |=> prdata[7:0] == BLOCKED_RD;
  endproperty
  a_lock: assert property (p_lock) else $error("locked read-back not blocked");

  property p_erase;
    @(posedge pclk) disable iff (!presetn)
    erase_done |=> code_mem[0] == ERASED && data_mem[0] == ERASED && !locked;
  endproperty
  a_erase: assert property (p_erase) else $error("erase left data");

  property p_erase_rd;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == RDATA_OFS && serial_q && st_q == ST_ERASE |=> prdata[7:0] == 8'h00;
  endproperty
  a_erase_rd: assert property (p_erase_rd) else $error("read during erase not zero");

  property p_erase_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(st_q == ST_ERASE) |-> (st_q == ST_ERASE) [*8];
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase ended early");

  property p_sfuse;
    @(posedge pclk) disable iff (!presetn)
    serial_q && !fuse_q[F_SERIAL] |=> !fuse_q[F_SERIAL];
  endproperty
  a_sfuse: assert property (p_sfuse) else $error("serial fuse enabled from serial mode");

  property p_sig;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == RDATA_OFS && !signature_select_a && !signature_select_b &&
    addr_q[ADDR_W-1:0] == SIG_ADDR1 && st_q == ST_IDLE |=> prdata[7:0] == SIG_VAL1;
  endproperty
  a_sig: assert property (p_sig) else $error("signature byte wrong");
endmodule

// ### fep_programmer.sv
`timescale 1ns/10ps
module fep_programmer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strobe_go,
  input wire logic sig_mode,
  input wire logic rb_o,
  input wire logic rb_oe,
  input wire logic pullup_en,
  output logic address_latch_strobe,
  output logic signature_select_a,
  output logic signature_select_b,
  output logic rb_line
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  // open-drain line, the external pull-up wins once released; with the pull-up dropped it sags low
  assign rb_line = rb_oe ? rb_o : pullup_en;
  // both selects low only while reading signatures
  assign signature_select_a = !sig_mode;
  assign signature_select_b = !sig_mode;
  // strobe held three cycles so a sampled edge is never missed
  always_comb begin
    cnt_d = cnt_q;
    if (strobe_go) begin
      cnt_d = 2'h3;
    end else if (cnt_q != 2'h0) begin
      cnt_d = cnt_q - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign address_latch_strobe = (cnt_q != 2'h0);
endmodule

// ### test_flash_eeprom_program_status.sv
`timescale 1ns/10ps
module test_flash_eeprom_program_status;
  import fep_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, alatch, sel_a, sel_b, rb_o, rb_oe, rb_line, clk_fuse, ser_en, ev;
  logic strobe_go = 1'b0;
  logic sig_mode = 1'b0;
  logic pullup_en = 1'b1;
  logic [31:0] rv;
  int miscompares = 0;
  int n_tests = 0;
  always #4 pclk = ~pclk;
  // short counts keep the run brief
  fep_prog #(.WRITE_CYCLES(6), .ERASE_CYCLES(12)) fep_prog_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .address_latch_strobe(alatch), .signature_select_a(sel_a),
    .signature_select_b(sel_b), .ready_busy_pin_o(rb_o), .ready_busy_pin_oe(rb_oe),
    .clock_source_fuse(clk_fuse), .serial_prog_enabled(ser_en));
  fep_programmer fep_programmer_inst (.pclk(pclk), .presetn(presetn), .strobe_go(strobe_go),
    .sig_mode(sig_mode), .rb_o(rb_o), .rb_oe(rb_oe), .pullup_en(pullup_en), .address_latch_strobe(alatch),
    .signature_select_a(sel_a), .signature_select_b(sel_b), .rb_line(rb_line));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one apb transfer, then an idle cycle so strobes never toggle twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // judge the timeout on the answer itself, not on the loop count
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  function automatic logic [31:0] ad(input logic [1:0] sp, input logic [9:0] a);
    return {20'h0, sp, a};
  endfunction
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, STATUS_OFS, 32'h0);
      n++;
    end while (rv[S_BUSY] !== 1'b0 && n < 40);
    if (rv[S_BUSY] !== 1'b0) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic wait_line(input logic lvl);
    int n;
    n = 0;
    while (rb_line !== lvl && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, rb_line}, {31'h0, lvl});
  endtask
  task automatic erase(input logic ser);
    wr(CTRL_OFS, {31'h0, ser});
    wr(CMD_OFS, {30'h0, OP_ERASE});
  endtask
  task automatic t_reset;
    rd(FUSE_OFS, {26'h0, FUSE_RST});
    chk({31'h0, ser_en}, 32'h1);
    chk({31'h0, clk_fuse}, 32'h0);
  endtask
  task automatic t_erase;
    wr(ADDR_OFS, ad(SPACE_CODE, 10'h003));
    erase(1'b0);
    rd(STATUS_OFS, 32'h0503);
    wait_idle();
    rd(RDATA_OFS, 32'hff);
    wr(ADDR_OFS, ad(SPACE_DATA, 10'h01f));
    rd(RDATA_OFS, 32'hff);
    erase(1'b1);
    rd(RDATA_OFS, 32'h0);
    wait_idle();
    rd(RDATA_OFS, 32'hff);
  endtask
  task automatic t_prog_ser;
    int n;
    n = 0;
    wr(ADDR_OFS, ad(SPACE_DATA, 10'h005));
    wr(WDATA_OFS, 32'ha5);
    wr(CMD_OFS, {30'h0, OP_PROG});
    rd(RDATA_OFS, 32'h25);
    do begin
      apb(1'b0, RDATA_OFS, 32'h0);
      n++;
    end while (rv !== 32'ha5 && n < 20);
    chk(rv, 32'ha5);
  endtask
  task automatic t_prog_par;
    wr(CTRL_OFS, 32'h0);
    wr(ADDR_OFS, ad(SPACE_CODE, 10'h010));
    wr(WDATA_OFS, 32'h7e);
    wr(CMD_OFS, {30'h0, OP_PROG});
    chk({31'h0, rb_line}, 32'h1);
    strobe_go <= 1'b1;
    @(posedge pclk);
    strobe_go <= 1'b0;
    wait_line(1'b0);
    rd(RDATA_OFS, 32'hfe);
    wait_line(1'b1);
    rd(RDATA_OFS, 32'h7e);
  endtask
  task automatic t_sig;
    sig_mode <= 1'b1;
    wr(ADDR_OFS, ad(SPACE_CODE, SIG_ADDR0));
    rd(RDATA_OFS, {24'h0, SIG_VAL0});
    wr(ADDR_OFS, ad(SPACE_CODE, SIG_ADDR1));
    rd(RDATA_OFS, {24'h0, SIG_VAL1});
    sig_mode <= 1'b0;
    rd(RDATA_OFS, 32'hff);
  endtask
  task automatic t_lock;
    wr(ADDR_OFS, ad(SPACE_CODE, 10'h010));
    wr(FUSE_OFS, 32'h35);
    rd(RDATA_OFS, 32'hff);
    rd(STATUS_OFS, 32'h3500);
    wr(FUSE_OFS, 32'h05);
    rd(FUSE_OFS, 32'h35);
    erase(1'b0);
    wait_idle();
    rd(FUSE_OFS, 32'h05);
  endtask
  task automatic t_user;
    wr(CTRL_OFS, 32'h1);
    wr(ADDR_OFS, ad(SPACE_USER, 10'h002));
    wr(WDATA_OFS, 32'h11);
    wr(FUSE_OFS, 32'h03);
    wr(CMD_OFS, {30'h0, OP_PROG});
    wait_idle();
    rd(RDATA_OFS, 32'hff);
    wr(FUSE_OFS, 32'h07);
    wr(CMD_OFS, {30'h0, OP_PROG});
    wait_idle();
    rd(RDATA_OFS, 32'h11);
    erase(1'b1);
    wait_idle();
    rd(RDATA_OFS, 32'h11);
    wr(FUSE_OFS, 32'h05);
    erase(1'b1);
    wait_idle();
    rd(RDATA_OFS, 32'hff);
  endtask
  task automatic t_fuse;
    wr(FUSE_OFS, 32'h0c);
    chk({31'h0, ser_en}, 32'h0);
    chk({31'h0, clk_fuse}, 32'h1);
    wr(FUSE_OFS, 32'h0d);
    rd(FUSE_OFS, 32'h0c);
    wr(CTRL_OFS, 32'h0);
    wr(FUSE_OFS, 32'h05);
    rd(FUSE_OFS, 32'h05);
    chk({31'h0, ser_en}, 32'h1);
    chk({31'h0, clk_fuse}, 32'h0);
  endtask
  // unmapped offset: error response, write dropped, read data zero
  task automatic t_bad;
    apb(1'b1, 8'h1c, 32'h1);
    chk({31'h0, ev}, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, ev}, 32'h1);
    chk(rv, 32'h0);
  endtask
  // power-off order: bus quiet, pull-up dropped, then reset; the device must let go of the line
  task automatic t_power_off;
    wr(FUSE_OFS, 32'h0c);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    @(posedge pclk);
    pullup_en <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({31'h0, rb_oe}, 32'h0);
    chk({31'h0, ser_en}, 32'h1);
    chk({31'h0, clk_fuse}, 32'h0);
    pullup_en <= 1'b1;
    presetn <= 1'b1;
    @(posedge pclk);
    rd(FUSE_OFS, {26'h0, FUSE_RST});
    chk({31'h0, rb_line}, 32'h1);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_erase();
    t_prog_ser();
    t_prog_par();
    t_sig();
    t_lock();
    t_user();
    t_fuse();
    t_bad();
    t_power_off();
    test_done();
  end
endmodule
